// ---- fpoc_cast.sv ----
// Fixed-point output cast with latency chain and AXI4-Lite control.
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fpoc_cast
   import fpoc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              ce,
   input  wire logic              sample_en,
   input  wire logic [IN_W-1:0]   in_data,
   input  wire logic              in_valid,
   output logic      [IN_W-1:0]   out_data,
   output logic                   out_valid,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic      [1:0]        s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic      [DATA_W-1:0] s_axi_rdata,
   output logic      [1:0]        s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   // ---------------------------------------------------------------
   // Build-time checks
   // ---------------------------------------------------------------
   // A bad format stops elaboration rather than producing a cast
   // whose range constants silently overflow.
   // The second check also keeps the quotient wider than the output,
   // which the range test needs in order to see an overflow at all.
   generate
      if (OUT_FRAC < 0 || OUT_FRAC > OUT_W)
      begin : g_bad_frac
         $error("Output fraction width out of range.");
      end
      if (SHIFT < 1 || Q_W <= OUT_W + 1)
      begin : g_bad_shift
         $error("Output format must drop fraction bits.");
      end
      if (LATENCY < 1)
      begin : g_bad_lat
         $error("Latency must be at least one sample.");
      end
   endgenerate

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   // Software sees four words, each on a 32-bit boundary:
   //   CTRL  read/write: user precision, saturate and round enables.
   //   STAT  write one to clear: overflow and quantisation-loss flags.
   //   COUNT samples taken; any write with a byte strobe set clears it.
   //   FMT   read-only: output width, fraction width, latency, sign.
   // A control change applies to the next sample that is taken; words
   // already in the chain keep the format they were cast with.
   // All register and bus state of this module, bus slots included, lives in one struct so that the
   // clock enable freezes the block as a whole.
   typedef struct packed {
      logic [CTRL_W-1:0]  ctrl;
      logic               ovf;
      logic               qerr;
      logic [COUNT_W-1:0] cnt;
      logic               aw_full;
      logic [ADDR_W-1:0]  aw_addr;
      logic               w_full;
      logic [DATA_W-1:0]  w_data;
      logic [3:0]         w_strb;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               rvalid;
      logic [DATA_W-1:0]  rdata;
      logic [1:0]         rresp;
   } fpoc_regs_s;

   fpoc_regs_s regs_q;
   fpoc_regs_s regs_d;

   // ---------------------------------------------------------------
   // Cast datapath
   // ---------------------------------------------------------------
   // The input is full precision by construction, so only the output
   // side needs range and rounding work. The output type is fixed at
   // build time; a signed build extends the result with its sign bit,
   // an unsigned one with zeros.
   // Limitation: the cast only ever drops fraction bits. A format that
   // would add fraction bits is refused by the checks above rather
   // than padded with zeros here.
   logic signed [Q_W-1:0] floor_v;
   logic signed [Q_W-1:0] quot_v;
   logic [SHIFT-1:0]      rem_v;
   logic                  neg_v;
   logic                  up_v;
   logic                  over_v;
   logic                  under_v;
   logic [OUT_W-1:0]      res_v;
   logic [IN_W-1:0]       cast_v;
   logic                  user_v;

   assign user_v = regs_q.ctrl[CTRL_USER];

   // The quotient is the input scaled to output LSBs, rounded toward
   // minus infinity by the arithmetic shift; one spare top bit keeps
   // the rounding carry from wrapping before the range test.
   always_comb
   begin
      neg_v   = in_data[IN_W-1];
      floor_v = {neg_v, in_data[IN_W-1:SHIFT]};
      rem_v   = in_data[SHIFT-1:0];
      // Above half always rounds up; exactly half rounds up only for
      // positive values, since floor already moved negatives away
      // from zero.
      up_v    = rem_v[SHIFT-1] & (~neg_v | (rem_v != RND_HALF));
      if (regs_q.ctrl[CTRL_RND] && up_v)
         quot_v = floor_v + Q_W'(1);
      else
         quot_v = floor_v;
      // Both bounds are compared on the quotient's signed scale, so a
      // rounding carry past the top is still caught as overflow.
      over_v  = quot_v > OUT_MAX;
      under_v = quot_v < OUT_MIN;
      if (regs_q.ctrl[CTRL_SAT] && over_v)
         res_v = OUT_MAX[OUT_W-1:0];
      else if (regs_q.ctrl[CTRL_SAT] && under_v)
         res_v = OUT_MIN[OUT_W-1:0];
      else
         res_v = quot_v[OUT_W-1:0];
      // Narrow results sit in the low bits of the wide output port,
      // extended according to the output type.
      if (user_v)
         cast_v = {{(IN_W - OUT_W){OUT_SIGNED & res_v[OUT_W-1]}},
                   res_v};
      else
         cast_v = in_data;
   end

   // ---------------------------------------------------------------
   // Latency chain
   // ---------------------------------------------------------------
   // Index zero is the combinational cast, index LATENCY the output
   // register. Invalid words travel the chain like valid ones, so a
   // gap in the input stream shows up as a gap at the output,
   // LATENCY sample periods later.
   logic [IN_W-1:0] chain_data [0:LATENCY];
   logic            chain_vld  [0:LATENCY];

   assign chain_data[0] = cast_v;
   assign chain_vld[0]  = in_valid;

   // Each stage holds one sample; all move on the same sample enable
   // so a word and its valid bit never part.
   generate
      for (genvar i = 0; i < LATENCY; i++)
      begin : g_chain
         fpoc_dly_stage u_stage (
            .clk       (clk),
            .sys_rst   (sys_rst),
            .ce        (ce),
            .adv       (sample_en),
            .in_data   (chain_data[i]),
            .in_valid  (chain_vld[i]),
            .out_data  (chain_data[i+1]),
            .out_valid (chain_vld[i+1])
         );
      end
   endgenerate

   assign out_data  = chain_data[LATENCY];
   assign out_valid = chain_vld[LATENCY];

   // ---------------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------------
   // Timing seen from the master: address and data are taken on the
   // first edge that offers them, the register is written one cycle
   // after both are held, and bvalid stands from then until bready.
   // A read answers one cycle after its address is taken. No slot or
   // flag moves while the clock enable is low, yet the ready outputs
   // are not gated by it, so a handshake made while frozen is lost.
   // Address and data are each caught in a holding slot, so the
   // master may offer them in either order; no new write is taken
   // while a response waits.
   assign s_axi_awready = ~regs_q.aw_full & ~regs_q.bvalid;
   assign s_axi_wready  = ~regs_q.w_full & ~regs_q.bvalid;
   assign s_axi_arready = ~regs_q.rvalid;
   assign s_axi_bvalid  = regs_q.bvalid;
   assign s_axi_bresp   = regs_q.bresp;
   assign s_axi_rvalid  = regs_q.rvalid;
   assign s_axi_rdata   = regs_q.rdata;
   assign s_axi_rresp   = regs_q.rresp;

   logic [ADDR_W-1:0] wr_word;
   logic [ADDR_W-1:0] rd_word;
   logic              do_write;
   logic              take_smp;

   // The two low address bits are ignored, so an unaligned address
   // reaches the word that contains it. With four address bits every
   // word is mapped; the error answer only guards a wider map.
   assign wr_word  = {regs_q.aw_addr[ADDR_W-1:2], 2'b00};
   assign rd_word  = {s_axi_araddr[ADDR_W-1:2], 2'b00};
   assign do_write = regs_q.aw_full & regs_q.w_full & ~regs_q.bvalid;
   assign take_smp = sample_en & in_valid;

   // Next state of the control registers, flags and bus slave.
   always_comb
   begin
      regs_d = regs_q;

      // Capture the two write channels independently.
      if (s_axi_awvalid && s_axi_awready)
      begin
         regs_d.aw_full = 1'b1;
         regs_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         regs_d.w_full = 1'b1;
         regs_d.w_data = s_axi_wdata;
         regs_d.w_strb = s_axi_wstrb;
      end
      if (regs_q.bvalid && s_axi_bready)
         regs_d.bvalid = 1'b0;

      // Perform the write once both halves are held.
      if (do_write)
      begin
         regs_d.aw_full = 1'b0;
         regs_d.w_full  = 1'b0;
         regs_d.bvalid  = 1'b1;
         regs_d.bresp   = RESP_OKAY;
         case (wr_word)
            OFF_CTRL:
               if (regs_q.w_strb[0])
                  regs_d.ctrl = regs_q.w_data[CTRL_W-1:0];
            OFF_STAT:
               if (regs_q.w_strb[0])
               begin
                  if (regs_q.w_data[STAT_OVF])
                     regs_d.ovf = 1'b0;
                  if (regs_q.w_data[STAT_QERR])
                     regs_d.qerr = 1'b0;
               end
            OFF_COUNT:
               if (|regs_q.w_strb)
                  regs_d.cnt = '0;
            OFF_FMT:
               regs_d.bresp = RESP_OKAY;
            default:
               regs_d.bresp = RESP_SLVERR;
         endcase
      end

      // Events are applied after the clears, so an event in the
      // clearing cycle keeps its flag set.
      if (take_smp && user_v)
      begin
         if (over_v || under_v)
            regs_d.ovf = 1'b1;
         if (rem_v != '0)
            regs_d.qerr = 1'b1;
      end
      // The count wraps silently after its top value; software that
      // needs long totals must read it often enough.
      if (take_smp)
         regs_d.cnt = regs_d.cnt + COUNT_W'(1);

      // Read channel: one answer at a time, data from a flip-flop.
      // Unused bits of a read word are zero.
      if (regs_q.rvalid && s_axi_rready)
         regs_d.rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         regs_d.rvalid = 1'b1;
         regs_d.rresp  = RESP_OKAY;
         regs_d.rdata  = '0;
         case (rd_word)
            OFF_CTRL:
               regs_d.rdata[CTRL_W-1:0] = regs_q.ctrl;
            OFF_STAT:
            begin
               regs_d.rdata[STAT_OVF]  = regs_q.ovf;
               regs_d.rdata[STAT_QERR] = regs_q.qerr;
            end
            OFF_COUNT:
               regs_d.rdata = regs_q.cnt;
            OFF_FMT:
            begin
               regs_d.rdata[FMT_W_POS +: 8]    = 8'(OUT_W);
               regs_d.rdata[FMT_FRAC_POS +: 8] = 8'(OUT_FRAC);
               regs_d.rdata[FMT_LAT_POS +: 8]  = 8'(LATENCY);
               regs_d.rdata[FMT_SGN_POS]       = OUT_SIGNED;
            end
            default:
               regs_d.rresp = RESP_SLVERR;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Reset selects full precision, so a block that software never
   // touches behaves as an exact pass-through with latency.
   // The clock enable gates every flip-flop here, so nothing, not even
   // a pending bus answer, moves while it is low.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         regs_q      <= '0;
         regs_q.ctrl <= CTRL_RESET;
      end
      else if (ce)
         regs_q <= regs_d;
   end

endmodule : fpoc_cast
`default_nettype wire

// ---- fpoc_pkg.sv ----
// Constants shared by the fixed-point output cast stage.
`default_nettype none
package fpoc_pkg;

   // ---------------------------------------------------------------
   // Number formats
   // ---------------------------------------------------------------
   // Full-precision input word, two's complement.
   localparam int IN_W       = 24;
   localparam int IN_FRAC    = 12;
   // User-defined output format.
   localparam int OUT_W      = 12;
   localparam int OUT_FRAC   = 6;
   localparam bit OUT_SIGNED = 1'b1;
   // Register stages after the cast, in sample periods.
   localparam int LATENCY    = 2;

   // Fraction bits dropped by the cast, and the width of the quotient
   // with one spare bit so that a rounding carry never overflows it.
   localparam int SHIFT = IN_FRAC - OUT_FRAC;
   localparam int Q_W   = IN_W - SHIFT + 1;

   // Weight of one half output LSB inside the dropped bits.
   localparam logic [SHIFT-1:0] RND_HALF = SHIFT'(1 << (SHIFT - 1));

   // Representable range of the output, on the quotient's scale.
   localparam logic signed [Q_W-1:0] OUT_MAX = OUT_SIGNED ?
      Q_W'((64'sd1 <<< (OUT_W - 1)) - 64'sd1) :
      Q_W'((64'sd1 <<< OUT_W) - 64'sd1);
   localparam logic signed [Q_W-1:0] OUT_MIN = OUT_SIGNED ?
      Q_W'(-(64'sd1 <<< (OUT_W - 1))) : Q_W'(0);

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int          ADDR_W    = 4;
   localparam int          DATA_W    = 32;
   localparam int          COUNT_W   = 32;
   localparam logic [3:0]  OFF_CTRL  = 4'h0;
   localparam logic [3:0]  OFF_STAT  = 4'h4;
   localparam logic [3:0]  OFF_COUNT = 4'h8;
   localparam logic [3:0]  OFF_FMT   = 4'hC;

   // Control bits and their value after reset (full precision).
   localparam int         CTRL_W       = 3;
   localparam int         CTRL_USER    = 0;
   localparam int         CTRL_SAT     = 1;
   localparam int         CTRL_RND     = 2;
   localparam logic [2:0] CTRL_RESET   = 3'h0;

   // Sticky status bits, written one to clear.
   localparam int STAT_OVF  = 0;
   localparam int STAT_QERR = 1;

   // Read-only format word fields.
   localparam int FMT_W_POS    = 0;
   localparam int FMT_FRAC_POS = 8;
   localparam int FMT_LAT_POS  = 16;
   localparam int FMT_SGN_POS  = 24;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fpoc_pkg
`default_nettype wire

// ---- fpoc_dly_stage.sv ----
// One register stage of the output latency chain, data with valid.
`timescale 1ns/1ps
`default_nettype none
module fpoc_dly_stage
   import fpoc_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            sys_rst,
   input  wire logic            ce,
   input  wire logic            adv,
   input  wire logic [IN_W-1:0] in_data,
   input  wire logic            in_valid,
   output logic      [IN_W-1:0] out_data,
   output logic                 out_valid
);

   typedef struct packed {
      logic [IN_W-1:0] data;
      logic            valid;
   } fpoc_stage_s;

   fpoc_stage_s stage_q;
   fpoc_stage_s stage_d;

   // The stage moves only once per sample period, so an overclocked
   // design still sees the latency in samples, not in clocks.
   always_comb
   begin
      stage_d = stage_q;
      if (adv)
      begin
         stage_d.data  = in_data;
         stage_d.valid = in_valid;
      end
   end

   // Clock enable low freezes the stage.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         stage_q <= '0;
      else if (ce)
         stage_q <= stage_d;
   end

   assign out_data  = stage_q.data;
   assign out_valid = stage_q.valid;

endmodule : fpoc_dly_stage
`default_nettype wire

// ---- fpoc_src_model.sv ----
// Upstream sample source that feeds words to the cast stage.
`timescale 1ns/1ps
`default_nettype none
module fpoc_src_model
   import fpoc_pkg::*;
#(
   parameter int DIV = 3
)
(
   input  wire logic            clk,
   input  wire logic            sys_rst,
   input  wire logic            run,
   input  wire logic [IN_W-1:0] nxt_data,
   input  wire logic            nxt_valid,
   output logic                 sample_en,
   output logic      [IN_W-1:0] in_data,
   output logic                 in_valid
);
   logic [7:0] cnt_q;

   // The period counter puts DIV clocks between two sample strobes.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         cnt_q <= 8'h00;
      else
         cnt_q <= (cnt_q == 8'(DIV - 1)) ? 8'h00 : cnt_q + 8'h01;
   end

   // When idle the word toggles, so stale data is never taken for real.
   always_comb
   begin
      sample_en = run && (cnt_q == 8'(DIV - 1));
      in_data   = run ? nxt_data : {IN_W/2{cnt_q[0], ~cnt_q[0]}};
      in_valid  = run && nxt_valid;
   end
endmodule : fpoc_src_model
`default_nettype wire

// ---- fpoc_cast_assertions.sv ----
// Concurrent checks on the ports of the fixed-point output cast.
`timescale 1ns/1ps
`default_nettype none
module fpoc_cast_chk
   import fpoc_pkg::*;
(
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic              ce,
   input wire logic              sample_en,
   input wire logic              in_valid,
   input wire logic [IN_W-1:0]   out_data,
   input wire logic              out_valid,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready
);
   // ----------------------------------------------------------
   // Reference valid chain and checks
   // ----------------------------------------------------------
   logic v1_q;
   logic v2_q;

   // Two stages, as the package fixes the latency at two periods.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         v1_q <= 1'b0;
         v2_q <= 1'b0;
      end
      else if (ce && sample_en)
      begin
         v1_q <= in_valid;
         v2_q <= v1_q;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   valid_lockstep_a: assert property (out_valid == v2_q)
      else $error("out_valid not delayed by two periods");
   stream_hold_a: assert property (!(ce && sample_en) |=>
      $stable(out_data) && $stable(out_valid))
      else $error("output moved without a sample strobe");
   wr_answer_a: assert property (ce && s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not two cycles after request");
   rd_answer_a: assert property (ce && s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read data not one cycle after address");
   bresp_stands_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   rdata_stands_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
   aw_refused_a: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   ar_refused_a: assert property (s_axi_arready != s_axi_rvalid)
      else $error("read ready not inverse of read valid");
endmodule : fpoc_cast_chk

bind fpoc_cast fpoc_cast_chk u_chk (.clk(clk), .sys_rst(sys_rst),
   .ce(ce), .sample_en(sample_en), .in_valid(in_valid),
   .out_data(out_data), .out_valid(out_valid),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ---- test_fpoc_cast.sv ----
// Self-checking testbench of the fixed-point output cast.
`timescale 1ns/1ps
`default_nettype none
module test_fpoc_cast;
   import fpoc_pkg::*;
   logic clk = 0, sys_rst = 1, ce = 1, run = 0, nxt_valid = 0;
   logic sample_en, in_valid, out_valid;
   logic [IN_W-1:0] nxt_data = '0, in_data, out_data;
   logic [3:0] awaddr = '0, araddr = '0, wstrb = 4'hF;
   logic [31:0] wdata = '0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   int miscompares = 0, tests_run = 0;
   logic [23:0] vec [6] = '{24'h000020, 24'hFFFFE0, 24'h000021,
                           24'h7FFFFF, 24'h800000, 24'h01FFE0};

   fpoc_src_model src (.clk(clk), .sys_rst(sys_rst), .run(run),
      .nxt_data(nxt_data), .nxt_valid(nxt_valid), .sample_en(sample_en),
      .in_data(in_data), .in_valid(in_valid));
   fpoc_cast dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
      .sample_en(sample_en), .in_data(in_data), .in_valid(in_valid),
      .out_data(out_data), .out_valid(out_valid), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));

   // ----------------------------------------------------------
   // Clock, checks and bus tasks
   // ----------------------------------------------------------
   // Half period of 25 ns gives the 20 MHz clock.
   always #25 clk = ~clk;

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      begin
         tests_run++;
         if (seen !== exp)
         begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask : chk

   task test_done;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, miscompares);
         if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask : test_done

   // Both channels are offered together and each released once taken.
   // Waits have no limit of their own; the watchdog ends a hung run.
   task wr(input logic [3:0] a, input logic [31:0] d);
      begin
         @(posedge clk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do
         begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
         end while (!bvalid);
         chk(bresp, RESP_OKAY);
         bready <= 1'b0;
      end
   endtask : wr

   task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] re);
      begin
         @(posedge clk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do
         begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
         end while (!rvalid);
         chk(rdata, e);
         chk(rresp, re);
         rready <= 1'b0;
      end
   endtask : rd

   // The word is held until the source's strobe edge takes it; one more
   // clock lets the chain settle, so outputs are looked at after the
   // edge that moved them and before the next strobe.
   task push(input logic [23:0] x, input logic v);
      begin
         nxt_data <= x;
         nxt_valid <= v;
         do @(posedge clk); while (!sample_en);
         @(posedge clk);
      end
   endtask : push

   // Bit-true model of the cast, worked independently of the design.
   function automatic logic [23:0] ref_cast(logic [23:0] x, logic [2:0] c);
      logic signed [24:0] q;
      begin
         q = 25'(signed'(x) >>> 6);
         if (c[2] && (x[5:0] > 6'h20 || (x[5:0] == 6'h20 && !x[23])))
            q = q + 25'sh1;
         if (c[1] && q > 25'sd2047) q = 25'sd2047;
         if (c[1] && q < -25'sd2048) q = -25'sd2048;
         return c[0] ? {{12{q[11]}}, q[11:0]} : x;
      end
   endfunction : ref_cast

   // ----------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------
   task t_regs;
      begin
         rd(OFF_CTRL, 32'h0, RESP_OKAY);
         rd(OFF_STAT, 32'h0, RESP_OKAY);
         rd(OFF_COUNT, 32'h0, RESP_OKAY);
         wr(OFF_FMT, 32'hFFFFFFFF);
         rd(OFF_FMT, 32'h0102060C, RESP_OKAY);
         // Low address bits are ignored: this reaches the control word.
         rd(4'h2, 32'h0, RESP_OKAY);
         $display("registers done");
      end
   endtask : t_regs

   // Every control mode, full precision ones included, on edge values.
   task t_cast;
      begin
         for (int m = 0; m < 8; m++)
         begin
            wr(OFF_CTRL, 32'(m));
            for (int i = 0; i < 6; i++)
            begin
               push(vec[i], 1'b1);
               chk(out_valid, 1'b0);
               push(24'h0, 1'b0);
               chk(out_data, ref_cast(vec[i], 3'(m)));
               chk(out_valid, 1'b1);
            end
         end
         $display("cast modes done");
      end
   endtask : t_cast

   // Sticky flags clear one bit at a time and the sample count.
   task t_stat;
      begin
         wr(OFF_CTRL, 32'h3);
         wr(OFF_STAT, 32'h3);
         wr(OFF_COUNT, 32'h0);
         push(24'h7FFFFF, 1'b1);
         push(24'h000040, 1'b1);
         push(24'h0, 1'b0);
         rd(OFF_STAT, 32'h3, RESP_OKAY);
         wr(OFF_STAT, 32'h1);
         rd(OFF_STAT, 32'h2, RESP_OKAY);
         rd(OFF_COUNT, 32'h2, RESP_OKAY);
         $display("status done");
      end
   endtask : t_stat

   // A low clock enable must stop the chain despite strobes.
   task t_freeze;
      begin
         wr(OFF_CTRL, 32'h0);
         push(24'h000100, 1'b1);
         push(24'h0, 1'b0);
         ce <= 1'b0;
         push(24'h000200, 1'b1);
         push(24'h000300, 1'b1);
         chk(out_data, 24'h000100);
         ce <= 1'b1;
         push(24'h0, 1'b0);
         push(24'h0, 1'b0);
         chk(out_valid, 1'b0);
         $display("freeze done");
      end
   endtask : t_freeze

   initial
   begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      run <= 1'b1;
      t_regs();
      t_cast();
      t_stat();
      t_freeze();
      test_done();
   end

   // The tests need well under two thousand cycles.
   initial
   begin
      #(20000 * 50);
      miscompares++;
      test_done();
   end
endmodule : test_fpoc_cast
`default_nettype wire
